// file: limit_monitor_consts.vh
/*
  Constants for the limit value monitor: register byte offsets, control
  field positions, reset values and encodings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LIMIT_MONITOR_CONSTS_VH
`define LIMIT_MONITOR_CONSTS_VH

// ****************************************************************
// Register byte offsets (one aligned 32-bit word each).
// ****************************************************************
`define OFS_CTRL      6'h00
`define OFS_LIMIT     6'h04
`define OFS_HYST      6'h08
`define OFS_DELAY     6'h0c
`define OFS_GRAD_DY   6'h10
`define OFS_GRAD_DT   6'h14
`define OFS_STATUS    6'h18
`define OFS_INT_STAT  6'h1c
`define OFS_INT_MASK  6'h20
`define OFS_MSG_ACK   6'h24
`define OFS_MSG_STAMP 6'h28

// ****************************************************************
// Control register fields.
// ****************************************************************
`define CTRL_EN       0
`define CTRL_KIND_LO  1
`define CTRL_KIND_HI  2
`define CTRL_HABS     3
`define CTRL_MSGNONE  4
`define CTRL_STALARM  5
`define CTRL_OSEL_LO  6
`define CTRL_OSEL_HI  8
`define CTRL_INV      9
`define CTRL_WIDTH    10
`define CTRL_RESET    10'h000

// Limit kinds.
`define KIND_UPPER    2'h0
`define KIND_LOWER    2'h1
`define KIND_GRAD     2'h2

// Output assignment codes: 0 none, 1..5 relays, 6 open collector.
`define OSEL_NONE     3'h0
`define OSEL_OC       3'h6

// Interrupt status bits.
`define IRQ_ENTER     0
`define IRQ_LEAVE     1
`define IRQ_ACK       2

// Reset values of the numeric settings, and the percent divisor.
`define LIMIT_RESET   16'h0000
`define HYST_RESET    16'h0000
`define DELAY_RESET   16'h0000
`define DY_RESET      16'h0000
`define DT_RESET      16'h0001
`define PCT_DIV       32'h0000_0064

// AXI response codes.
`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3

`endif

// file: limit_qualifier.v
/*
  Limit qualifier: per-sample comparison, delay timer, hysteresis release
  and gradient detection for one channel.
  Assumes samples arrive on core_clk with a one-cycle strobe.
*/
`timescale 1ns/1ps
`include "limit_monitor_consts.vh"

module limit_qualifier (
  input  wire               core_clk,
  input  wire               srst,
  input  wire               enable,      // Monitoring switched on.
  input  wire               sampleValid, // One-cycle sample strobe.
  input  wire signed [15:0] sample,      // Measured value, process unit.
  input  wire        [1:0]  kind,        // Upper, lower or gradient.
  input  wire signed [15:0] limitVal,    // Limit value.
  input  wire        [15:0] hyst,        // Margin, percent or absolute.
  input  wire               hystAbs,     // High selects absolute margin.
  input  wire        [15:0] delaySamples,// Qualifying time in samples.
  input  wire        [15:0] gradDy,      // Gradient change amount.
  input  wire        [15:0] gradDt,      // Gradient span in samples.
  output reg                limitState,  // Limit state held.
  output reg                enterPulse,  // One cycle on entering.
  output reg                leavePulse   // One cycle on leaving.
);

  // ****************************************************************
  // Margin and comparison.
  // ****************************************************************
  wire signed [17:0] s18   = {{2{sample[15]}}, sample};   // Widened sample.
  wire signed [17:0] l18   = {{2{limitVal[15]}}, limitVal}; // Widened limit.
  wire        [15:0] limAbs = limitVal[15] ? (~limitVal + 16'h0001) : limitVal;
  wire        [31:0] pctProd = limAbs * hyst;             // Percent product.
  wire        [31:0] pctMargin = pctProd / `PCT_DIV;      // Margin in units.
  wire        [16:0] margin = hystAbs ? {1'b0, hyst} : pctMargin[16:0];
  wire signed [17:0] m18 = {1'b0, margin};                // Signed margin.
  reg                beyond;                              // Sample violates.
  reg                backIn;                              // Sample back in.
  reg signed  [15:0] gradRef_q;                           // Span start value.
  reg         [15:0] gradCnt_q;                           // Samples in span.
  wire signed [17:0] gDiff = s18 - {{2{gradRef_q[15]}}, gradRef_q};
  wire        [17:0] gAbs = gDiff[17] ? (~gDiff + 18'h00001) : gDiff;
  wire               gHit = (gAbs >= {2'h0, gradDy});     // Fast change seen.
  reg         [15:0] dlyCnt_q;                            // Delay counter.
  wire        [15:0] dlyNext = dlyCnt_q + 16'h0001;       // Count incl. now.

  // Violation and release tests for the selected kind. For the upper and lower
  // kinds the release point sits inside the normal range by the margin, so a
  // signal hovering at the limit cannot toggle the state every sample.
  always @* begin
    case (kind)
      `KIND_UPPER: begin
        beyond = (s18 > l18);
        backIn = (s18 <= (l18 - m18));
      end
      `KIND_LOWER: begin
        beyond = (s18 < l18);
        backIn = (s18 >= (l18 + m18));
      end
      `KIND_GRAD: begin
        beyond = gHit;
        backIn = ~gHit;
      end
      default: begin
        beyond = 1'b0;
        backIn = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Gradient span tracking.
  // ****************************************************************
  // A new span starts when the set number of samples has passed; the value
  // at the start is the reference the change is measured against.
  always @(posedge core_clk) begin
    if (srst) begin
      gradRef_q <= 16'h0000;
      gradCnt_q <= 16'h0000;
    end else if (sampleValid) begin
      if (gradCnt_q >= gradDt) begin
        gradRef_q <= sample;
        gradCnt_q <= 16'h0000;
      end else begin
        gradCnt_q <= gradCnt_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Delay timer and limit state.
  // ****************************************************************
  // Counts in samples; a delay of 0 or 1 enters on the first violation.
  always @(posedge core_clk) begin
    if (srst) begin
      limitState <= 1'b0;
      dlyCnt_q   <= 16'h0000;
      enterPulse <= 1'b0;
      leavePulse <= 1'b0;
    end else begin
      enterPulse <= 1'b0;
      leavePulse <= 1'b0;
      if (!enable) begin
        // Switching off drops the state quietly, without an event.
        limitState <= 1'b0;
        dlyCnt_q   <= 16'h0000;
      end else if (sampleValid) begin
        if (!limitState) begin
          if (beyond) begin
            if (dlyNext >= delaySamples) begin
              limitState <= 1'b1;
              enterPulse <= 1'b1;
              dlyCnt_q   <= 16'h0000;
            end else begin
              dlyCnt_q <= dlyNext;
            end
          end else begin
            dlyCnt_q <= 16'h0000;
          end
        end else if (backIn) begin
          limitState <= 1'b0;
          leavePulse <= 1'b1;
        end
      end
    end
  end

endmodule

// file: limit_value_monitor.v
/*
  Limit value monitor top: AXI4-Lite register file, limit qualifier,
  switch output with polarity, message handling, store cycle selection
  and interrupt.
  Assumes samples and the time stamp come from logic on core_clk; the OK
  key arrives from a pin and is synchronised here.
*/
`timescale 1ns/1ps
`include "limit_monitor_consts.vh"

module limit_value_monitor (
  input  wire               core_clk,
  input  wire               srst,
  // AXI4-Lite slave.
  input  wire        [5:0]  s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire        [31:0] s_axi_wdata,
  input  wire        [3:0]  s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output reg         [1:0]  s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire        [5:0]  s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output reg         [31:0] s_axi_rdata,
  output reg         [1:0]  s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Measurement side.
  input  wire               sampleValid,
  input  wire signed [15:0] sampleData,
  input  wire        [31:0] timeNow,
  input  wire               okKeyPin,
  // Outputs.
  output reg         [4:0]  relayOut,
  output reg                ocOut,
  output reg                msgShow,
  output reg                msgIsLeave,
  output reg         [31:0] msgStamp,
  output reg                redMark,
  output reg                alarmCycle,
  output wire               irq
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  reg  [`CTRL_WIDTH-1:0] ctrl_q;     // Control fields.
  reg  [15:0]            limit_q;    // Limit value, signed.
  reg  [15:0]            hyst_q;     // Hysteresis amount.
  reg  [15:0]            delay_q;    // Delay in samples.
  reg  [15:0]            dy_q;       // Gradient amount.
  reg  [15:0]            dt_q;       // Gradient span in samples.
  reg  [2:0]             intStat_q;  // Sticky event bits.
  reg  [2:0]             intMask_q;  // Interrupt enables.
  reg                    msgPend_q;  // Message waiting for OK.
  reg                    msgLeave_q; // Pending message is the leave text.
  reg  [31:0]            stamp_q;    // Event date and time.

  // ****************************************************************
  // AXI write channel.
  // ****************************************************************
  reg         awHeld_q;              // Write address captured.
  reg         wHeld_q;               // Write data captured.
  reg  [5:0]  awAddr_q;              // Captured address.
  reg  [31:0] wData_q;               // Captured data.
  reg  [3:0]  wStrb_q;               // Captured strobes.
  wire        doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid; // Commit now.
  wire [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                       {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};   // Byte lanes.
  wire [31:0] wBits = wData_q & wMask; // Data in enabled lanes only.
  reg         wMapped;               // Write address decodes.

  // Either order; each channel stalls once its own item is held.
  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready  = ~wHeld_q;

  // Capture the two write channels and produce the response.
  always @(posedge core_clk) begin
    if (srst) begin
      awHeld_q     <= 1'b0;
      wHeld_q      <= 1'b0;
      awAddr_q     <= 6'h00;
      wData_q      <= 32'h0000_0000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wMapped ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Mapped offsets; read-only words answer OKAY, ignore data.
  always @* begin
    case (awAddr_q)
      `OFS_CTRL, `OFS_LIMIT, `OFS_HYST, `OFS_DELAY, `OFS_GRAD_DY,
      `OFS_GRAD_DT, `OFS_STATUS, `OFS_INT_STAT, `OFS_INT_MASK,
      `OFS_MSG_ACK, `OFS_MSG_STAMP: wMapped = 1'b1;
      default: wMapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  // Each field keeps its old bits in lanes whose strobe is low.
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl_q    <= `CTRL_RESET;
      limit_q   <= `LIMIT_RESET;
      hyst_q    <= `HYST_RESET;
      delay_q   <= `DELAY_RESET;
      dy_q      <= `DY_RESET;
      dt_q      <= `DT_RESET;
      intMask_q <= 3'h0;
    end else if (doWrite) begin
      case (awAddr_q)
        `OFS_CTRL:     ctrl_q <= (ctrl_q & ~wMask[`CTRL_WIDTH-1:0]) | wBits[`CTRL_WIDTH-1:0];
        `OFS_LIMIT:    limit_q   <= (limit_q & ~wMask[15:0]) | wBits[15:0];
        `OFS_HYST:     hyst_q    <= (hyst_q & ~wMask[15:0]) | wBits[15:0];
        `OFS_DELAY:    delay_q   <= (delay_q & ~wMask[15:0]) | wBits[15:0];
        `OFS_GRAD_DY:  dy_q      <= (dy_q & ~wMask[15:0]) | wBits[15:0];
        `OFS_GRAD_DT:  dt_q      <= (dt_q & ~wMask[15:0]) | wBits[15:0];
        `OFS_INT_MASK: intMask_q <= (intMask_q & ~wMask[2:0]) | wBits[2:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Qualifier.
  // ****************************************************************
  wire limitState; // Channel in limit state.
  wire enterPulse; // Entered this cycle.
  wire leavePulse; // Left this cycle.

  limit_qualifier qual (
    .core_clk     (core_clk),
    .srst         (srst),
    .enable       (ctrl_q[`CTRL_EN]),
    .sampleValid  (sampleValid),
    .sample       (sampleData),
    .kind         (ctrl_q[`CTRL_KIND_HI:`CTRL_KIND_LO]),
    .limitVal     (limit_q),
    .hyst         (hyst_q),
    .hystAbs      (ctrl_q[`CTRL_HABS]),
    .delaySamples (delay_q),
    .gradDy       (dy_q),
    .gradDt       (dt_q),
    .limitState   (limitState),
    .enterPulse   (enterPulse),
    .leavePulse   (leavePulse)
  );

  // ****************************************************************
  // OK key synchroniser and message handling.
  // ****************************************************************
  reg  okSync1_q; // First stage, read only by the second.
  reg  okSync2_q; // Second stage.
  reg  okPrev_q;  // Previous level for edge detection.
  wire okPress = okSync2_q & ~okPrev_q;                       // Key pressed.
  wire swAck   = doWrite & (awAddr_q == `OFS_MSG_ACK) & wBits[0]; // Software OK.
  wire ackMode = ~ctrl_q[`CTRL_MSGNONE];                      // Acknowledge mode.
  wire msgEvt  = ackMode & (enterPulse | leavePulse);         // New message.
  wire ackDone = msgPend_q & (okPress | swAck) & ~msgEvt;     // Operator OK.

  // Two flops before the key is used, since it comes from a pin.
  always @(posedge core_clk) begin
    if (srst) begin
      okSync1_q <= 1'b0;
      okSync2_q <= 1'b0;
      okPrev_q  <= 1'b0;
    end else begin
      okSync1_q <= okKeyPin;
      okSync2_q <= okSync1_q;
      okPrev_q  <= okSync2_q;
    end
  end

  // A new event replaces a pending message and wins over an OK in the same
  // cycle, so the operator never misses the latest transition.
  always @(posedge core_clk) begin
    if (srst) begin
      msgPend_q  <= 1'b0;
      msgLeave_q <= 1'b0;
      stamp_q    <= 32'h0000_0000;
    end else if (msgEvt) begin
      msgPend_q  <= 1'b1;
      msgLeave_q <= leavePulse;
      stamp_q    <= timeNow;
    end else if (ackDone) begin
      msgPend_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt status.
  // ****************************************************************
  wire [2:0] evts = {ackDone, leavePulse, enterPulse};      // Event bits.
  wire [2:0] w1c  = (doWrite && awAddr_q == `OFS_INT_STAT) ? wBits[2:0] : 3'h0;

  // Set wins over a write-one-to-clear landing in the same cycle.
  always @(posedge core_clk) begin
    if (srst) begin
      intStat_q <= 3'h0;
    end else begin
      intStat_q <= (intStat_q & ~w1c) | evts;
    end
  end

  assign irq = |(intStat_q & intMask_q);

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  wire [2:0] oSel   = ctrl_q[`CTRL_OSEL_HI:`CTRL_OSEL_LO];  // Assigned output.
  wire       active = limitState ^ ctrl_q[`CTRL_INV];
  wire       relSel = (oSel != `OSEL_NONE) && (oSel < `OSEL_OC); // A relay.
  wire [2:0] relIdx = oSel - 3'h1;                          // Relay index.

  // Level high means the relay is energised (changeover on relay one,
  // contact closed on the others) or the open collector conducts. With no
  // output assigned everything rests de-energised, whatever the polarity.
  always @(posedge core_clk) begin
    if (srst) begin
      relayOut   <= 5'h00;
      ocOut      <= 1'b0;
      msgShow    <= 1'b0;
      msgIsLeave <= 1'b0;
      msgStamp   <= 32'h0000_0000;
      redMark    <= 1'b0;
      alarmCycle <= 1'b0;
    end else begin
      relayOut   <= relSel ? ({4'h0, active} << relIdx) : 5'h00;
      ocOut      <= (oSel == `OSEL_OC) & active;
      msgShow    <= msgPend_q;
      msgIsLeave <= msgLeave_q;
      msgStamp   <= stamp_q;
      redMark    <= limitState & ctrl_q[`CTRL_MSGNONE];
      alarmCycle <= limitState & ctrl_q[`CTRL_STALARM];
    end
  end

  // ****************************************************************
  // AXI read channel.
  // ****************************************************************
  reg [31:0] rWord;   // Decoded read data.
  reg        rMapped; // Read address decodes.

  assign s_axi_arready = ~s_axi_rvalid;

  // Read decode; reserved bits read as zero.
  always @* begin
    rMapped = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL:      rWord = {22'h000000, ctrl_q};
      `OFS_LIMIT:     rWord = {16'h0000, limit_q};
      `OFS_HYST:      rWord = {16'h0000, hyst_q};
      `OFS_DELAY:     rWord = {16'h0000, delay_q};
      `OFS_GRAD_DY:   rWord = {16'h0000, dy_q};
      `OFS_GRAD_DT:   rWord = {16'h0000, dt_q};
      `OFS_STATUS:    rWord = {27'h0000000, alarmCycle, redMark, msgLeave_q,
                               msgPend_q, limitState};
      `OFS_INT_STAT:  rWord = {29'h00000000, intStat_q};
      `OFS_INT_MASK:  rWord = {29'h00000000, intMask_q};
      `OFS_MSG_ACK:   rWord = 32'h0000_0000;
      `OFS_MSG_STAMP: rWord = stamp_q;
      default: begin
        rWord   = 32'h0000_0000;
        rMapped = 1'b0;
      end
    endcase
  end

  // One read in flight; the answer follows the address by one cycle.
  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rWord;
      s_axi_rresp  <= rMapped ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: alarm_panel.sv
/* Far-side model: an alarm lamp on relay 1 and an operator with an OK key.
   Assumes it runs on the monitor's clock; the key is pressed only on request. */
`timescale 1ns/1ps
module alarm_panel (
  input  wire core_clk, // Shared clock.
  input  wire relayIn,  // Relay 1 contact, closed when high.
  input  wire msgShow,  // Message pending on the screen.
  input  wire pressReq, // Operator wants to press OK.
  output reg  okKeyPin, // OK key, high while pressed.
  output reg  lampOn    // Lamp wired to the relay contact.
);
  initial okKeyPin = 1'b0;
  initial lampOn = 1'b0;
  // Press only while a message is up.
  always @(posedge core_clk) begin
    okKeyPin <= pressReq && msgShow;
    lampOn <= relayIn;
  end
endmodule

// file: limit_value_monitor_checker.sv
/* Port checker for the limit value monitor.
   Assumes it is bound to the monitor top. */
`timescale 1ns/1ps
module limit_value_monitor_checker (
  input wire        core_clk,
  input wire        srst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [4:0]  relayOut,
  input wire        ocOut,
  input wire        msgShow
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Only the one assigned output may be active at a time.
  property p_one_relay; $onehot0(relayOut); endproperty
  a_one_relay: assert property (p_one_relay) else $error("several relays active");
  property p_out_excl; !(ocOut && (|relayOut)); endproperty
  a_out_excl: assert property (p_out_excl) else $error("relay and oc both active");
  // Leaving reset, the relay, open collector and msgShow outputs are idle.
  property p_rst_out; $fell(srst) |-> relayOut == 5'h00 && !ocOut && !msgShow; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("read taken while busy");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
endmodule

// file: limit_value_monitor_tb.sv
/* Bench for the limit value monitor: register tasks and limit scenarios.
   Assumes the checker and the alarm panel model are compiled first. */
`timescale 1ns/1ps
`include "limit_monitor_consts.vh"
module limit_value_monitor_tb;
  reg               core_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg               s_axi_arvalid, s_axi_rready, sampleValid, pressReq;
  reg        [5:0]  s_axi_awaddr, s_axi_araddr;
  reg        [31:0] s_axi_wdata, timeNow, rdVal;
  reg        [3:0]  s_axi_wstrb;
  reg signed [15:0] sampleData;
  reg        [1:0]  rdResp, wrResp;
  wire              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire              okKeyPin, lampOn, ocOut, msgShow, msgIsLeave, redMark, alarmCycle, irq;
  wire       [1:0]  s_axi_bresp, s_axi_rresp;
  wire       [31:0] s_axi_rdata, msgStamp;
  wire       [4:0]  relayOut;
  integer           errors, nTests;
  integer           cyc = 0;
  limit_value_monitor uut (.*);
  alarm_panel pnl (.core_clk(core_clk), .relayIn(relayOut[0]), .msgShow(msgShow),
    .pressReq(pressReq), .okKeyPin(okKeyPin), .lampOn(lampOn));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Ceiling far beyond the test length.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      results;
    end
  end
  // ****************************************************************
  // Register and sample tasks.
  // ****************************************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      nTests = nTests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Sampled mid-cycle, settled before the next edge.
  task wr(input [5:0] a, input [31:0] d);
    integer k;
    reg ta, tw, bv, done;
    begin
      done = 0;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!done && k < 40) begin
        @(negedge core_clk);
        k = k + 1;
        ta = s_axi_awready;
        tw = s_axi_wready;
        bv = s_axi_bvalid;
        done = bv && s_axi_bready;
        wrResp = s_axi_bresp;
        @(posedge core_clk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (bv && !done) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      if (!done) errors = errors + 1;
      @(posedge core_clk);
    end
  endtask
  task rd(input [5:0] a);
    integer k;
    reg ta, rv, done;
    begin
      done = 0;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!done && k < 40) begin
        @(negedge core_clk);
        k = k + 1;
        ta = s_axi_arready;
        rv = s_axi_rvalid;
        done = rv && s_axi_rready;
        rdVal = s_axi_rdata;
        rdResp = s_axi_rresp;
        @(posedge core_clk);
        if (ta) s_axi_arvalid <= 1'b0;
        if (rv && !done) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      if (!done) errors = errors + 1;
      @(posedge core_clk);
    end
  endtask
  // Strobe, then let outputs settle.
  task smp(input signed [15:0] v);
    begin
      sampleData <= v;
      sampleValid <= 1'b1;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task results;
    begin
      $display("Comparisons %0d, mismatches %0d", nTests, errors);
      if (errors == 0 && nTests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    errors = 0;
    nTests = 0;
    {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h10;
    {s_axi_rready, sampleValid, pressReq, s_axi_awaddr, s_axi_araddr} = 15'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    sampleData = 16'sh0000;
    timeNow = 32'h0000_a5a5;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(`OFS_CTRL); chk(rdVal, 32'h0000_0000);
    rd(`OFS_GRAD_DT); chk(rdVal, 32'h0000_0001);
    rd(6'h3c); chk(32'(rdResp), 32'h0000_0003);
    wr(6'h3c, 32'h0000_0001); chk(32'(wrResp), 32'h0000_0003);
    $display("done: reset values");
    wr(`OFS_INT_MASK, 32'h0000_0007);
    wr(`OFS_LIMIT, 32'h0000_0064);
    wr(`OFS_HYST, 32'h0000_000a);
    wr(`OFS_DELAY, 32'h0000_0003);
    wr(`OFS_CTRL, 32'h0000_0049);
    smp(16'sd101); smp(16'sd101); smp(16'sd50);
    chk(32'(relayOut), 32'h0000_0000);
    smp(16'sd101); smp(16'sd101); smp(16'sd101);
    chk(32'(relayOut), 32'h0000_0001);
    chk(32'({msgShow, msgIsLeave, irq}), 32'h0000_0005);
    chk(msgStamp, 32'h0000_a5a5);
    chk(32'(lampOn), 32'h0000_0001);
    rd(`OFS_STATUS); chk(rdVal & 32'h0000_0001, 32'h0000_0001);
    wr(`OFS_INT_STAT, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
    pressReq <= 1'b1;
    repeat (8) @(posedge core_clk);
    pressReq <= 1'b0;
    chk(32'(msgShow), 32'h0000_0000);
    smp(16'sd95);
    chk(32'(relayOut), 32'h0000_0001);
    smp(16'sd90);
    chk(32'({relayOut, msgShow, msgIsLeave}), 32'h0000_0003);
    wr(`OFS_MSG_ACK, 32'h0000_0001);
    chk(32'(msgShow), 32'h0000_0000);
    $display("done: upper limit, delay, hysteresis");
    wr(`OFS_INT_STAT, 32'h0000_0007);
    wr(`OFS_DELAY, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_03b3);
    repeat (3) @(posedge core_clk);
    chk(32'(ocOut), 32'h0000_0001);
    smp(16'sd99);
    chk(32'({ocOut, redMark, alarmCycle, msgShow, relayOut}), 32'h0000_00c0);
    smp(16'sd105);
    chk(32'(ocOut), 32'h0000_0000);
    smp(16'sd110);
    chk(32'({ocOut, redMark, alarmCycle}), 32'h0000_0004);
    $display("done: lower limit, inverted oc");
    wr(`OFS_GRAD_DY, 32'h0000_0014);
    wr(`OFS_CTRL, 32'h0000_0045);
    smp(16'sd0); smp(16'sd25); smp(16'sd50); smp(16'sd75);
    chk(32'(relayOut), 32'h0000_0001);
    $display("done: gradient");
    results;
  end
endmodule
bind limit_value_monitor limit_value_monitor_checker chk_i (.*);
